/* hw/eep_spi_dev.sv */
// Command decoder, protection and page write of a serial EEPROM slave.
// Assumes the serial pins are asynchronous to i_clk and that the serial
// clock is far slower than i_clk (at least five i_clk periods a phase).
`timescale 1ns/1ps
module eep_spi_dev
  import eep_pkg::*;
#(
  parameter int AW        = ADDR_W,
  parameter int PG_AW     = PAGE_AW,
  parameter int WC_CYCLES = WC_CYC
) (
  // Clock, reset, enable
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  // Serial pins from the master
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  input  wire logic i_hold_n,
  input  wire logic i_wp_n,
  // Serial output pin
  output logic      o_so,
  output logic      o_so_en_n
);

  localparam int WCW = $clog2(WC_CYCLES + 1);

  // Pin synchronisers
  logic [4:0]    sync1_q;
  logic [4:0]    sync2_q;
  logic          sck_prev_q;
  logic          cs_prev_q;
  logic          hold_q;
  // Serial engine
  eep_state_type st_q;
  logic [3:0]    cnt_q;
  logic [15:0]   sh_q;
  logic [AW-1:0] addr_q;
  logic          rd_op_q;
  logic          sr_got_q;
  logic [7:0]    sr_new_q;
  // Output shifter
  logic [7:0]    osh_q;
  logic [2:0]    ocnt_q;
  logic          ld_q;
  logic          started_q;
  logic          so_q;
  logic          so_en_n_q;
  // Protection and write cycle
  logic          wel_q;
  logic [1:0]    bp_q;
  logic          ppe_q;
  logic          busy_q;
  logic          arr_op_q;
  logic [WCW-1:0] wc_cnt_q;
  logic [7:0]    pg_buf_q [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pg_vld_q;

  function automatic logic eep_is(input logic [7:0] opc,
                                  input logic [2:0] code);
    eep_is = (opc[7:4] == OPC_HI_ZERO) && (opc[2:0] == code);
  endfunction

  function automatic logic eep_prot(input logic [1:0] bp,
                                    input logic [AW-1:0] a);
    unique case (bp)
      BP_QUARTER: eep_prot = (a[AW-1:AW-2] == 2'h3);
      BP_HALF:    eep_prot = a[AW-1];
      BP_ALL:     eep_prot = 1'b1;
      default:    eep_prot = 1'b0;
    endcase
  endfunction

  // Synchronised pins
  wire cs_n_s   = sync2_q[0];
  wire sck_s    = sync2_q[1];
  wire si_s     = sync2_q[2];
  wire hold_n_s = sync2_q[3];
  wire wp_n_s   = sync2_q[4];

  // edges count only when selected and not held
  wire act       = ~cs_n_s & ~hold_q;
  wire sck_rise  = act & sck_s & ~sck_prev_q;
  wire sck_fall  = act & ~sck_s & sck_prev_q;
  wire cs_fall   = ~cs_n_s & cs_prev_q;
  wire cs_rise   = cs_n_s & ~cs_prev_q;

  wire [7:0]  opc_full  = {sh_q[6:0], si_s};
  wire [15:0] addr_full = {sh_q[14:0], si_s};
  wire dec_set   = eep_is(opc_full, OPC_LATCH_SET);
  wire dec_clr   = eep_is(opc_full, OPC_LATCH_CLEAR);
  wire dec_srr   = eep_is(opc_full, OPC_STATUS_READ);
  wire dec_srw   = eep_is(opc_full, OPC_STATUS_WRITE);
  wire dec_read  = eep_is(opc_full, OPC_ARRAY_READ);
  wire dec_write = eep_is(opc_full, OPC_ARRAY_WRITE);

  wire opc_done = sck_rise & (st_q == ST_OPC) & (cnt_q == 4'h7);
  wire adr_done = sck_rise & (st_q == ST_ADDR) & (cnt_q == 4'hf);
  wire byte_in  = sck_rise & (cnt_q[2:0] == 3'h7);
  wire wr_byte  = byte_in & (st_q == ST_WR);
  wire out_st   = (st_q == ST_RD) | (st_q == ST_SRR);
  wire out_done = sck_fall & out_st & (ocnt_q == 3'h7);
  wire shift_st = (st_q == ST_OPC) | (st_q == ST_ADDR) |
                  (st_q == ST_WR) | (st_q == ST_SRW);

  // write with latch clear is dropped
  wire eep_state_type st_opc_nxt =
    dec_srr                     ? ST_SRR  :
    busy_q                      ? ST_IGN  :
    dec_read                    ? ST_ADDR :
    (dec_write & wel_q)         ? ST_ADDR :
    dec_srw                     ? ST_SRW  :
                                  ST_IGN;

  wire [3:0] cnt_nxt = (st_q == ST_ADDR) ? cnt_q + 4'h1 :
                       {1'b0, cnt_q[2:0] + 3'h1};

  wire [7:0] status = busy_q ? SR_IN_CYCLE :
                      {ppe_q, 3'h0, bp_q, wel_q, 1'b0};

  wire hw_prot = ~wp_n_s & ppe_q;

  // commit on deselect after whole bytes only
  wire arr_go = (st_q == ST_WR) & (|pg_vld_q) & (cnt_q == 4'h0) &
                wel_q & ~eep_prot(bp_q, addr_q);
  // status write needs latch and no pin protection
  wire sr_go  = (st_q == ST_SRW) & sr_got_q & (cnt_q == 4'h0) &
                wel_q & ~hw_prot;
  wire wr_go  = cs_rise & ~busy_q & (arr_go | sr_go);
  wire wc_end = busy_q & (wc_cnt_q == WCW'(WC_CYCLES - 1));

  // Array commit during the first cycles of the timed write
  wire [PG_AW-1:0] cm_idx = wc_cnt_q[PG_AW-1:0];
  wire cm_we = busy_q & arr_op_q & (wc_cnt_q < WCW'(PAGE_BYTES)) &
               pg_vld_q[cm_idx];
  wire [AW-1:0] cm_addr = {addr_q[AW-1:PG_AW], cm_idx};
  wire [7:0]    mem_rd;

  // Pin sampling; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_q    <= PIN_RST;
      sync2_q    <= PIN_RST;
      sck_prev_q <= PIN_RST[1];
      cs_prev_q  <= PIN_RST[0];
    end else if (i_ce) begin
      sync1_q    <= {i_wp_n, i_hold_n, i_si, i_sck, i_cs_n};
      sync2_q    <= sync1_q;
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_n_s;
    end
  end

  // hold changes only while the serial clock is low, except that deselect clears it at once
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_q <= 1'b0;
    end else if (i_ce) begin
      if (cs_n_s) begin
        hold_q <= 1'b0;
      end else if (!sck_s) begin
        hold_q <= ~hold_n_s;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 16'h0000;
      addr_q  <= '0;
      rd_op_q <= 1'b0;
    end else if (i_ce) begin
      if (cs_n_s) begin
        st_q <= ST_IDLE;
      end else if (cs_fall) begin
        st_q  <= ST_OPC;
        cnt_q <= 4'h0;
      end else if (sck_rise && shift_st) begin
        sh_q  <= addr_full;
        cnt_q <= cnt_nxt;
        if (opc_done) begin
          st_q    <= st_opc_nxt;
          rd_op_q <= dec_read;
          cnt_q   <= 4'h0;
        end
        if (adr_done) begin
          st_q   <= rd_op_q ? ST_RD : ST_WR;
          addr_q <= addr_full[AW-1:0];
          cnt_q  <= 4'h0;
        end
        if (wr_byte) begin
          addr_q[PG_AW-1:0] <= addr_q[PG_AW-1:0] + PG_AW'(1);
        end
      end
      // sequential read wraps over the array
      if (out_done && st_q == ST_RD) begin
        addr_q <= addr_q + AW'(1);
      end
    end
  end

  // Page buffer and staged status byte
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pg_vld_q <= '0;
      sr_got_q <= 1'b0;
      sr_new_q <= 8'h00;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        pg_buf_q[i] <= 8'h00;
      end
    end else if (i_ce) begin
      if (opc_done) begin
        pg_vld_q <= '0;
        sr_got_q <= 1'b0;
      end
      // excess bytes overwrite earlier page slots
      if (wr_byte) begin
        pg_buf_q[addr_q[PG_AW-1:0]] <= opc_full;
        pg_vld_q[addr_q[PG_AW-1:0]] <= 1'b1;
      end
      if (byte_in && st_q == ST_SRW) begin
        sr_new_q <= opc_full;
        sr_got_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wel_q <= WEL_RST;
    end else if (i_ce) begin
      if (wc_end) begin
        wel_q <= 1'b0;
      end else if (opc_done && !busy_q && dec_set) begin
        wel_q <= 1'b1;
      end else if (opc_done && !busy_q && dec_clr) begin
        wel_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_q   <= 1'b0;
      arr_op_q <= 1'b0;
      wc_cnt_q <= '0;
      bp_q     <= BP_RST;
      ppe_q    <= PPE_RST;
    end else if (i_ce) begin
      if (wr_go) begin
        busy_q   <= 1'b1;
        arr_op_q <= arr_go;
        wc_cnt_q <= '0;
      end else if (wc_end) begin
        busy_q <= 1'b0;
        if (!arr_op_q) begin
          bp_q  <= {sr_new_q[SR_BP_HI_BIT], sr_new_q[SR_BP_LO_BIT]};
          ppe_q <= sr_new_q[SR_PPE_BIT];
        end
      end else if (busy_q) begin
        wc_cnt_q <= wc_cnt_q + WCW'(1);
      end
    end
  end

  // output shifter advances at falling serial clock
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      osh_q     <= 8'h00;
      ocnt_q    <= 3'h0;
      ld_q      <= 1'b0;
      started_q <= 1'b0;
      so_q      <= 1'b0;
    end else if (i_ce) begin
      ld_q <= (opc_done & (st_opc_nxt == ST_SRR)) |
              (adr_done & rd_op_q) | out_done;
      if (cs_fall) begin
        ocnt_q    <= 3'h0;
        started_q <= 1'b0;
      end
      // Reload one cycle late so the address update settles first
      if (ld_q) begin
        osh_q <= (st_q == ST_SRR) ? status : mem_rd;
      end else if (sck_fall && out_st) begin
        so_q      <= osh_q[7];
        osh_q     <= {osh_q[6:0], 1'b0};
        ocnt_q    <= ocnt_q + 3'h1;
        started_q <= 1'b1;
      end
    end
  end

  // output driven only while shifting out
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      so_en_n_q <= 1'b1;
    end else if (i_ce) begin
      so_en_n_q <= ~(out_st & act & (started_q | sck_fall));
    end
  end

  eep_store #(
    .AW   (AW),
    .DW   (DATA_W),
    .INIT (ERASED_BYTE)
  ) u_store (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_we    (cm_we),
    .i_waddr (cm_addr),
    .i_wdata (pg_buf_q[cm_idx]),
    .i_raddr (addr_q),
    .o_rdata (mem_rd)
  );

  assign o_so      = so_q;
  assign o_so_en_n = so_en_n_q;

endmodule

/* hw/eep_pkg.sv */
// Constants, opcodes and state codes of the serial EEPROM command block.
// Assumes a 125 MHz system clock that samples all serial pins.
package eep_pkg;

  // System clock and self-timed write cycle
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_WC_MS       = 5;
  // Longest time, so rounded down
  localparam int WC_CYC        = (T_WC_MS * 1000000) / CLK_PERIOD_NS;

  // Array geometry (largest density)
  localparam int ADDR_W      = 13;
  localparam int ADDR_BITS   = 16;
  localparam int PAGE_AW     = 5;
  localparam int PAGE_BYTES  = 32;
  localparam int DATA_W      = 8;

  // Opcode layout: upper nibble zero, bit 3 ignored
  localparam logic [3:0] OPC_HI_ZERO      = 4'h0;
  localparam logic [2:0] OPC_LATCH_SET    = 3'h6;
  localparam logic [2:0] OPC_LATCH_CLEAR  = 3'h4;
  localparam logic [2:0] OPC_STATUS_READ  = 3'h5;
  localparam logic [2:0] OPC_STATUS_WRITE = 3'h1;
  localparam logic [2:0] OPC_ARRAY_READ   = 3'h3;
  localparam logic [2:0] OPC_ARRAY_WRITE  = 3'h2;

  // protection_status field positions
  localparam int SR_BUSY_BIT  = 0;
  localparam int SR_WEL_BIT   = 1;
  localparam int SR_BP_LO_BIT = 2;
  localparam int SR_BP_HI_BIT = 3;
  localparam int SR_PPE_BIT   = 7;
  localparam logic [7:0] SR_IN_CYCLE = 8'hff;

  // Block-protect field codes
  localparam logic [1:0] BP_NONE    = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF    = 2'h2;
  localparam logic [1:0] BP_ALL     = 2'h3;

  // Reset values
  localparam logic       WEL_RST     = 1'b0;
  localparam logic [1:0] BP_RST      = 2'h0;
  localparam logic       PPE_RST     = 1'b0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Idle pin levels: wp_n, hold_n, si, sck, cs_n
  localparam logic [4:0] PIN_RST     = 5'h19;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_OPC  = 8'h02,
    ST_ADDR = 8'h04,
    ST_RD   = 8'h08,
    ST_WR   = 8'h10,
    ST_SRR  = 8'h20,
    ST_SRW  = 8'h40,
    ST_IGN  = 8'h80
  } eep_state_type;

endpackage

/* hw/eep_store.sv */
// Byte storage of the EEPROM array, one flip-flop word per location.
// Assumes one writer; the read port is combinational.
`timescale 1ns/1ps
module eep_store #(
  parameter int AW = 13,
  parameter int DW = 8,
  parameter logic [7:0] INIT = 8'hff
) (
  // Clock, reset, enable
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_ce,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // Reset models an erased part, not retained contents
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < (1<<AW); i++) begin
        mem_q[i] <= INIT[DW-1:0];
      end
    end else if (i_ce && i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem_q[i_raddr];

endmodule

/* tb/eep_sva.sv */
// Pin-level assertions for the serial EEPROM slave.
// Assumes serial phases of five clocks and select high of ten or more.
`timescale 1ns/1ps
module eep_sva (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic o_so,
  input wire logic o_so_en_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn || !i_ce);
  desel_hiz_a: assert property (
    $rose(i_cs_n) |-> ##[1:5] o_so_en_n) else $error("SO left driven");
  hold_hiz_a: assert property (
    (!i_hold_n) [*6] |-> o_so_en_n) else $error("SO driven in hold");
  opc_quiet_a: assert property (
    $fell(i_cs_n) |-> o_so_en_n [*8]) else $error("SO driven in opcode");
  so_low_phase_a: assert property (
    !o_so_en_n && $changed(o_so) |-> !i_sck) else $error("SO moved high");
  so_steady_a: assert property (
    !o_so_en_n && i_sck && $past(i_sck) |-> $stable(o_so))
    else $error("SO unstable");
  en_needs_cs_a: assert property (
    $fell(o_so_en_n) |-> !i_cs_n && i_hold_n) else $error("SO unselected");
  en_fall_low_a: assert property (
    $fell(o_so_en_n) |-> !i_sck) else $error("SO enabled in high phase");
  en_off_cause_a: assert property (
    $rose(o_so_en_n) |-> i_cs_n || !i_hold_n) else $error("SO dropped early");
endmodule
bind eep_spi_dev eep_sva eep_sva_inst (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_ce(i_ce), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si),
  .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_en_n(o_so_en_n));

/* tb/eep_host.sv */
// Host master model driving the EEPROM serial pins in mode 0.
// Assumes a 125 MHz clock; each serial phase lasts five clocks.
`timescale 1ns/1ps
module eep_host (
  // Clock and slave output
  input  wire logic i_clk,
  input  wire logic i_so,
  input  wire logic i_so_en_n,
  // Master pins
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  output logic      o_hold_n
);
  logic so_last;
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    o_hold_n = 1'b1;
    so_last = 1'b0;
  end
  task automatic half();
    repeat (5) @(posedge i_clk);
  endtask
  // shift in low phase, sample before rise
  task automatic bit_x(input logic b, output logic r);
    o_si <= b;
    half();
    // Floating SO reads as the inverse of the last bit, not as the last bit
    r = i_so_en_n ? ~so_last : i_so;
    so_last = r;
    o_sck <= 1'b1;
    half();
    o_sck <= 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
  endtask
  task automatic sel();
    o_cs_n <= 1'b0;
    half();
  endtask
  // deselect in the low phase after the last bit
  task automatic desel();
    repeat (2) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_si <= ~o_si;
    repeat (12) @(posedge i_clk);
  endtask
  // pause in low phase; the stray clock edges must be ignored
  task automatic pause();
    half();
    o_hold_n <= 1'b0;
    half();
    o_sck <= 1'b1;
    half();
    o_sck <= 1'b0;
    half();
    o_hold_n <= 1'b1;
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench of the EEPROM slave driven by the host model.
// Assumes the package, design, checker and host model come first.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb
  import eep_pkg::*;
;
  logic       i_clk, i_rstn, i_ce, i_wp_n, o_so, o_so_en_n;
  logic       cs_n, sck, si, hold_n, wel, ppe, en_seen;
  logic [1:0] bp;
  logic [7:0] d, s, mem [8192];
  logic [12:0] a;
  int         n_fail, n_tests;
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  eep_spi_dev #(.WC_CYCLES(2000)) eep_spi_dev_inst (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_ce(i_ce), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_en_n(o_so_en_n));
  eep_host eep_host_inst (.i_clk(i_clk), .i_so(o_so), .i_so_en_n(o_so_en_n),
    .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_hold_n(hold_n));
  always @(posedge i_clk) begin
    if (o_so_en_n === 1'b0) en_seen <= 1'b1;
  end
  function automatic logic [7:0] op(logic [2:0] c);
    return {OPC_HI_ZERO, 1'($urandom), c};
  endfunction
  function automatic logic [7:0] st_exp();
    return {ppe, 3'h0, bp, wel, 1'b0};
  endfunction
  function automatic logic prot(logic [12:0] x);
    return bp == BP_ALL || (bp == BP_HALF && x[12]) ||
      (bp == BP_QUARTER && x[12:11] == 2'h3);
  endfunction
  task automatic xb(input logic [7:0] o);
    eep_host_inst.byte_x(o, d);
  endtask
  task automatic cmd(input logic [2:0] c);
    eep_host_inst.sel();
    xb(op(c));
    eep_host_inst.desel();
  endtask
  task automatic sr_rd();
    eep_host_inst.sel();
    xb(op(OPC_STATUS_READ));
    xb(8'($urandom));
    eep_host_inst.desel();
    s = d;
  endtask
  // A refused command never enables SO
  task automatic probe(input logic [7:0] o);
    en_seen <= 1'b0;
    eep_host_inst.sel();
    xb(o);
    repeat (3) xb(op(OPC_STATUS_READ));
    eep_host_inst.desel();
    `CHK(en_seen, 1'b0)
  endtask
  task automatic settle();
    sr_rd();
    `CHK(s, SR_IN_CYCLE)
    probe(op(OPC_ARRAY_READ));
    cmd(OPC_LATCH_SET);
    for (int i = 0; i < 20 && s === SR_IN_CYCLE; i++) begin
      sr_rd();
    end
    wel = 1'b0;
    `CHK(s, st_exp())
  endtask
  task automatic wr(input logic [12:0] x, input int n, input logic en);
    logic [7:0] v;
    if (en) cmd(OPC_LATCH_SET);
    wel = en;
    eep_host_inst.sel();
    xb(op(OPC_ARRAY_WRITE));
    xb({3'($urandom), x[12:8]});
    xb(x[7:0]);
    for (int i = 0; i < n; i++) begin
      v = 8'($urandom);
      xb(v);
      if (wel && !prot(x)) mem[{x[12:5], 5'(x[4:0] + i)}] = v;
    end
    eep_host_inst.desel();
    if (wel && !prot(x)) settle();
    else begin
      sr_rd();
      `CHK(s, st_exp())
    end
  endtask
  task automatic rd(input logic [12:0] x, input int n, input logic hold);
    eep_host_inst.sel();
    xb(op(OPC_ARRAY_READ));
    xb({3'($urandom), x[12:8]});
    xb(x[7:0]);
    for (int i = 0; i < n; i++) begin
      if (hold && i == 1) eep_host_inst.pause();
      xb(8'($urandom));
      `CHK(d, mem[13'(x + i)])
    end
    eep_host_inst.desel();
  endtask
  task automatic sw(input logic [7:0] v);
    cmd(OPC_LATCH_SET);
    wel = 1'b1;
    eep_host_inst.sel();
    xb(op(OPC_STATUS_WRITE));
    xb(v);
    eep_host_inst.desel();
    if (i_wp_n || !ppe) begin
      ppe = v[7];
      bp = v[3:2];
      settle();
    end else begin
      sr_rd();
      `CHK(s, st_exp())
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge i_clk);
    n_fail++;
    conclude();
  end
  initial begin
    {i_rstn, i_ce, i_wp_n, wel, ppe, bp, en_seen} = 8'h60;
    {n_fail, n_tests} = '0;
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    void'($urandom(2947));
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clk);
    sr_rd();
    `CHK(s, 8'h00)
    cmd(OPC_LATCH_SET);
    sr_rd();
    `CHK(s, 8'h02)
    i_wp_n <= 1'b0;
    cmd(OPC_LATCH_CLEAR);
    sr_rd();
    `CHK(s, 8'h00)
    i_wp_n <= 1'b1;
    probe({4'($urandom_range(15, 1)), 4'($urandom)});
    probe(8'h07);
    wr(13'h0010, 2, 1'b0);
    rd(13'h0010, 2, 1'b0);
    a = {8'($urandom), 5'h1e};
    wr(a, 34, 1'b1);
    rd({a[12:5], 5'h0}, 33, 1'b1);
    wr(13'h1fff, 1, 1'b1);
    rd(13'h1ffe, 4, 1'b0);
    sw(8'h84);
    wr(13'h1800 | 13'($urandom_range(2047)), 1, 1'b1);
    wr(13'h17e0, 2, 1'b1);
    rd(13'h17df, 3, 1'b0);
    i_wp_n <= 1'b0;
    sw(8'h00);
    i_wp_n <= 1'b1;
    sw(8'h7c);
    wr(13'($urandom), 1, 1'b1);
    sw(8'h00);
    rd(13'h17fe, 4, 1'b0);
    conclude();
  end
endmodule
